// File: pemv_pkg.sv
/*
 * Shared constants for the port egress permission block: port counts,
 * register offsets, control fields, presets and the fixed VLAN identifier.
 * Assumes a single system clock; nothing here holds logic.
 */
package pemv_pkg;
    localparam int NPORT = 12;
    localparam int NEGR  = 13;
    localparam int PORTW = 4;
    localparam int MACW  = 48;
    localparam int NMAC  = 16;
    localparam int IDXW  = 4;
    localparam int VIDW  = 12;
    localparam int ADRW  = 8;

    localparam logic [PORTW-1:0] CPU_PORT  = 4'hc;
    localparam logic [VIDW-1:0]  VID_FIXED = 12'h001;

    localparam logic [NEGR-1:0] MASK_ALL  = 13'h1fff;
    localparam logic [NEGR-1:0] MASK_ISO  = 13'h1000;
    localparam logic [NEGR-1:0] MASK_NONE = 13'h0000;

    localparam logic [ADRW-1:0] OFS_CTRL  = 8'h00;
    localparam logic [ADRW-1:0] OFS_VID   = 8'h04;
    localparam logic [ADRW-1:0] OFS_COUNT = 8'h08;
    localparam logic [ADRW-1:0] OFS_COL0  = 8'h40;
    localparam logic [ADRW-1:0] OFS_COLN  = 8'h6c;

    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_PRE_LSB  = 1;
    localparam int CTRL_SAVE_BIT = 3;

    localparam logic [1:0] PRE_NONE = 2'h0;
    localparam logic [1:0] PRE_ALL  = 2'h1;
    localparam logic [1:0] PRE_ISO  = 2'h2;

    localparam logic CTRL_EN_RST = 1'b1;
endpackage

// File: pemv_mask_col.sv
/*
 * One column of the permission matrix: the outgoing ports that one
 * ingress port may reach. Assumes write and preset strobes are one-cycle
 * pulses from the register logic on the same clock.
 */
module pemv_mask_col (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      arst_n,
    // updates
    input  wire logic                      wrEn,
    input  wire logic [pemv_pkg::NEGR-1:0] wrData,
    input  wire logic                      presetAll,
    input  wire logic                      presetIso,
    // column contents
    output logic      [pemv_pkg::NEGR-1:0] colMask
);
    typedef struct packed {
        logic [pemv_pkg::NEGR-1:0] mask;
    } pemv_col_t;

    pemv_col_t stQ;
    pemv_col_t stD;

    always_comb begin
        stD = stQ;
        if (presetAll) begin
            stD.mask = pemv_pkg::MASK_ALL; // R6
        end else if (presetIso) begin
            stD.mask = pemv_pkg::MASK_ISO; // R7
        end else if (wrEn) begin
            stD.mask = wrData; // R2
        end
    end

    // volatile storage, comes back all connected after reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stQ.mask <= pemv_pkg::MASK_ALL; // R9 R12
        end else begin
            stQ <= stD;
        end
    end

    assign colMask = stQ.mask;
endmodule

// File: pemv_mac_table.sv
/*
 * Small learned address table mapping a station address to its port.
 * Lookup is combinational; learning overwrites a matching entry or the
 * next entry in round-robin order. Assumes requests on the same clock.
 */
module pemv_mac_table (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // lookup
    input  wire logic [pemv_pkg::MACW-1:0]  lookMac,
    output logic                            hit,
    output logic      [pemv_pkg::PORTW-1:0] hitPort,
    // learning
    input  wire logic                       learnEn,
    input  wire logic [pemv_pkg::MACW-1:0]  learnMac,
    input  wire logic [pemv_pkg::PORTW-1:0] learnPort,
    output logic      [pemv_pkg::IDXW:0]    used
);
    typedef struct packed {
        logic [pemv_pkg::NMAC-1:0]                       valid;
        logic [pemv_pkg::NMAC-1:0][pemv_pkg::MACW-1:0]   mac;
        logic [pemv_pkg::NMAC-1:0][pemv_pkg::PORTW-1:0]  port;
        logic [pemv_pkg::IDXW-1:0]                       next;
        logic [pemv_pkg::IDXW:0]                         used;
    } pemv_tab_t;

    pemv_tab_t stQ;
    pemv_tab_t stD;
    logic      learnHit;
    logic [pemv_pkg::IDXW-1:0] learnIdx;

    always_comb begin
        hit      = 1'b0;
        hitPort  = '0;
        learnHit = 1'b0;
        learnIdx = stQ.next;
        for (int i = 0; i < pemv_pkg::NMAC; i++) begin
            if (stQ.valid[i] && stQ.mac[i] == lookMac) begin
                hit     = 1'b1;
                hitPort = stQ.port[i];
            end
            if (stQ.valid[i] && stQ.mac[i] == learnMac) begin
                learnHit = 1'b1;
                learnIdx = i[pemv_pkg::IDXW-1:0];
            end
        end
    end

    always_comb begin
        stD = stQ;
        if (learnEn) begin
            stD.valid[learnIdx] = 1'b1;
            stD.mac[learnIdx]   = learnMac;
            stD.port[learnIdx]  = learnPort;
            if (!learnHit) begin
                stD.next = stQ.next + 1'b1;
                if (!stQ.valid[learnIdx]) begin
                    stD.used = stQ.used + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stQ <= '0;
        end else begin
            stQ <= stD;
        end
    end

    assign used = stQ.used;
endmodule

// File: pemv_egress_filter.sv
/*
 * Port-based egress permission block for a twelve-port switch with an
 * internal management port. Holds the permission matrix behind an APB
 * slave and answers per-frame forwarding requests with an egress mask.
 * Assumes one system clock; forwarding requests come from logic on it.
 */
// What this block does
// [R1] forwarding uses the destination address's learned port, limited by the matrix
// [R2] every ingress port has its own independently written egress set
// [R3] traffic flows both ways only when each port permits the other
// [R4] with port-based operation on, the VLAN identifier is fixed at 1
// [R5] other functions needing a VLAN identifier must be given 1
// [R6] all-connected preset sets every permission bit including management
// [R7] isolation preset sets only the management egress bit in every column
// [R8] under isolation, front ports reach management only, never each other
// [R9] after reset the management port is grouped with every port
// [R10] frames for management from an unjoined front port are dropped
// [R11] columns are ingress ports, rows egress ports plus the management row
// [R12] matrix is volatile; a separate save strobe hands it to storage
// [R13] frames go only to permitted egress ports, dropped toward all others
module pemv_egress_filter (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pemv_pkg::ADRW-1:0]  paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // forwarding request
    input  wire logic                       fwdReq,
    input  wire logic [pemv_pkg::PORTW-1:0] fwdIngress,
    input  wire logic [pemv_pkg::MACW-1:0]  fwdDstMac,
    input  wire logic [pemv_pkg::MACW-1:0]  fwdSrcMac,
    input  wire logic                       fwdToCpu,
    // forwarding answer
    output logic                            fwdValid,
    output logic      [pemv_pkg::NEGR-1:0]  fwdEgress,
    output logic      [pemv_pkg::VIDW-1:0]  fwdVid,
    // storage hand-off
    output logic                            saveStrobe,
    output logic      [pemv_pkg::NPORT-1:0][pemv_pkg::NEGR-1:0] saveImage
);
    typedef struct packed {
        logic                      rdy;
        logic [31:0]               rdata;
        logic                      err;
        logic                      enable;
        logic                      save;
        logic                      valid;
        logic [pemv_pkg::NEGR-1:0] egress;
    } pemv_top_t;

    pemv_top_t stQ;
    pemv_top_t stD;

    logic [pemv_pkg::NPORT-1:0][pemv_pkg::NEGR-1:0] colMask;
    logic [pemv_pkg::NPORT-1:0]                      colWr;
    logic [pemv_pkg::NEGR-1:0]                       selMask;
    logic [pemv_pkg::NEGR-1:0]                       selfBit;
    logic [pemv_pkg::NEGR-1:0]                       dstBit;
    logic                                            accFirst;
    logic                                            accDone;
    logic                                            ctrlWr;
    logic                                            presetAll;
    logic                                            presetIso;
    logic                                            isCol;
    logic [pemv_pkg::ADRW-1:0]                       colOfs;
    logic [pemv_pkg::PORTW-1:0]                      colIdx;
    logic                                            tabHit;
    logic [pemv_pkg::PORTW-1:0]                      tabPort;
    logic [pemv_pkg::IDXW:0]                         tabUsed;
    logic                                            ingOk;

    // apb phases: one wait state, then the write commits with pready
    assign accFirst  = psel && penable && !stQ.rdy;
    assign accDone   = psel && penable && stQ.rdy;
    assign ctrlWr    = accDone && pwrite && paddr == pemv_pkg::OFS_CTRL;
    assign presetAll = ctrlWr && pwdata[pemv_pkg::CTRL_PRE_LSB +: 2] == pemv_pkg::PRE_ALL;
    assign presetIso = ctrlWr && pwdata[pemv_pkg::CTRL_PRE_LSB +: 2] == pemv_pkg::PRE_ISO;
    assign isCol     = paddr >= pemv_pkg::OFS_COL0 && paddr <= pemv_pkg::OFS_COLN && paddr[1:0] == 2'h0;
    assign colOfs    = paddr - pemv_pkg::OFS_COL0;
    assign colIdx    = colOfs[pemv_pkg::PORTW+1:2];

    // one column per ingress port, the management row as top bit
    genvar g;
    generate
        for (g = 0; g < pemv_pkg::NPORT; g++) begin : gCol
            assign colWr[g] = accDone && pwrite && isCol && colIdx == pemv_pkg::PORTW'(g); // R2 R11
            pemv_mask_col uCol (
                .clk       (clk),
                .arst_n    (arst_n),
                .wrEn      (colWr[g]),
                .wrData    (pwdata[pemv_pkg::NEGR-1:0]),
                .presetAll (presetAll),
                .presetIso (presetIso),
                .colMask   (colMask[g])
            );
        end
    endgenerate

    pemv_mac_table uTab (
        .clk       (clk),
        .arst_n    (arst_n),
        .lookMac   (fwdDstMac),
        .hit       (tabHit),
        .hitPort   (tabPort),
        .learnEn   (fwdReq && ingOk),
        .learnMac  (fwdSrcMac),
        .learnPort (fwdIngress),
        .used      (tabUsed)
    );

    assign ingOk   = fwdIngress < pemv_pkg::PORTW'(pemv_pkg::NPORT);
    assign selMask = ingOk ? colMask[fwdIngress] : pemv_pkg::MASK_NONE;
    assign selfBit = pemv_pkg::NEGR'(1) << fwdIngress;
    assign dstBit  = fwdToCpu ? (pemv_pkg::NEGR'(1) << pemv_pkg::CPU_PORT)
                              : (pemv_pkg::NEGR'(1) << tabPort);

    always_comb begin
        logic [pemv_pkg::NEGR-1:0] allow;
        logic [pemv_pkg::NEGR-1:0] want;
        allow = '0;
        want  = '0;
        stD   = stQ;
        stD.save  = 1'b0;
        stD.valid = fwdReq;
        // disabled: nothing restricts forwarding beyond the ingress port
        allow = stQ.enable ? selMask : pemv_pkg::MASK_ALL; // R3 R13
        if (!ingOk) begin
            allow = pemv_pkg::MASK_NONE;
        end
        if (fwdToCpu || tabHit) begin
            want = dstBit; // R1 R10
        end else begin
            want = pemv_pkg::MASK_ALL;
        end
        stD.egress = fwdReq ? (want & allow & ~selfBit) : pemv_pkg::MASK_NONE; // R8 R13

        stD.rdy = accFirst;
        if (accFirst) begin
            stD.err   = 1'b0;
            stD.rdata = '0;
            if (paddr == pemv_pkg::OFS_CTRL) begin
                stD.rdata[pemv_pkg::CTRL_EN_BIT] = stQ.enable;
            end else if (paddr == pemv_pkg::OFS_VID) begin
                stD.rdata[pemv_pkg::VIDW-1:0] = pemv_pkg::VID_FIXED; // R4
                stD.err = pwrite;
            end else if (paddr == pemv_pkg::OFS_COUNT) begin
                stD.rdata[pemv_pkg::IDXW:0] = tabUsed;
                stD.err = pwrite;
            end else if (isCol) begin
                stD.rdata[pemv_pkg::NEGR-1:0] = colMask[colIdx];
            end else begin
                stD.err = 1'b1;
            end
        end
        if (ctrlWr) begin
            stD.enable = pwdata[pemv_pkg::CTRL_EN_BIT];
            stD.save   = pwdata[pemv_pkg::CTRL_SAVE_BIT]; // R12
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stQ        <= '0;
            stQ.enable <= pemv_pkg::CTRL_EN_RST;
        end else begin
            stQ <= stD;
        end
    end

    assign prdata     = stQ.rdata;
    assign pready     = stQ.rdy;
    assign pslverr    = stQ.rdy && stQ.err;
    assign fwdValid   = stQ.valid;
    assign fwdEgress  = stQ.egress;
    // other functions reading this see the same fixed identifier
    assign fwdVid     = pemv_pkg::VID_FIXED; // R4 R5
    assign saveStrobe = stQ.save;
    assign saveImage  = colMask;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    apb_wait_one_a: assert property (accFirst |=> pready ##1 !pready)
        else $error("apb answer not one wait state");
    fwd_latency_a: assert property (fwdReq |=> fwdValid) // R13
        else $error("forwarding answer missing");
    vid_fixed_a: assert property (pready && !pwrite && paddr == pemv_pkg::OFS_VID // R4
                                  |-> prdata[pemv_pkg::VIDW-1:0] == pemv_pkg::VID_FIXED
                                      && fwdVid == pemv_pkg::VID_FIXED)
        else $error("vlan identifier not fixed");
    no_self_a: assert property (fwdReq && ingOk |=> !fwdEgress[$past(fwdIngress)]) // R13
        else $error("frame sent back to ingress");
    within_mask_a: assert property (fwdReq && stQ.enable |=> (fwdEgress & ~$past(selMask)) == '0) // R3
        else $error("egress outside permission set");
    cpu_drop_a: assert property (fwdReq && fwdToCpu && stQ.enable && !selMask[pemv_pkg::CPU_PORT]
                                 |=> fwdEgress == '0) // R10
        else $error("management frame leaked");
    unicast_hit_a: assert property (fwdReq && tabHit && !fwdToCpu |=> $countones(fwdEgress) <= 1) // R1
        else $error("known destination flooded");
    preset_iso_a: assert property (presetIso |=> colMask == {pemv_pkg::NPORT{pemv_pkg::MASK_ISO}}) // R7
        else $error("isolation preset not applied");
    preset_all_a: assert property (presetAll |=> colMask == {pemv_pkg::NPORT{pemv_pkg::MASK_ALL}}) // R6
        else $error("all connected preset not applied");
    save_pulse_a: assert property (saveStrobe |=> !saveStrobe) // R12
        else $error("save strobe longer than a cycle");
    iso_front_a: assert property (colMask == {pemv_pkg::NPORT{pemv_pkg::MASK_ISO}} && stQ.enable
                                  && fwdReq && !fwdToCpu |=> fwdEgress[pemv_pkg::NPORT-1:0] == '0) // R8
        else $error("isolated front ports exchanged traffic");

    flood_cv: cover property (fwdReq && !tabHit && !fwdToCpu ##1 fwdValid);
    iso_cv: cover property (presetIso ##[1:20] fwdReq && fwdToCpu);
    err_cv: cover property (pready && pslverr);
endmodule

// File: pemv_station.sv
/*
 * Station-side model: launches one frame decision per go pulse and keeps
 * the last egress answer. Assumes the bench raises go for one cycle.
 */
module pemv_station (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       arst_n,
    // bench control
    input  wire logic                       go,
    input  wire logic [pemv_pkg::PORTW-1:0] goIngress,
    input  wire logic [pemv_pkg::MACW-1:0]  goDst,
    input  wire logic [pemv_pkg::MACW-1:0]  goSrc,
    input  wire logic                       goCpu,
    // towards the block
    output logic                            fwdReq,
    output logic      [pemv_pkg::PORTW-1:0] fwdIngress,
    output logic      [pemv_pkg::MACW-1:0]  fwdDstMac,
    output logic      [pemv_pkg::MACW-1:0]  fwdSrcMac,
    output logic                            fwdToCpu,
    // answers
    input  wire logic                       fwdValid,
    input  wire logic [pemv_pkg::NEGR-1:0]  fwdEgress,
    input  wire logic [pemv_pkg::VIDW-1:0]  fwdVid,
    output logic      [pemv_pkg::NEGR-1:0]  rxMask,
    output logic      [pemv_pkg::VIDW-1:0]  rxVid,
    output int                              rxCnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside a request the fields toggle so stale values never look valid
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fwdReq     <= 1'b0;
            fwdIngress <= '0;
            fwdDstMac  <= '0;
            fwdSrcMac  <= '0;
            fwdToCpu   <= 1'b0;
            rxMask     <= '0;
            rxVid      <= '0;
            rxCnt      <= 0;
        end else begin
            fwdReq <= go;
            fwdIngress <= go ? goIngress : ~fwdIngress;
            fwdDstMac <= go ? goDst : ~fwdDstMac;
            fwdSrcMac <= go ? goSrc : ~fwdSrcMac;
            fwdToCpu <= go ? goCpu : ~fwdToCpu;
            if (fwdValid === 1'b1) begin
                rxMask <= fwdEgress;
                rxVid <= fwdVid;
                rxCnt <= rxCnt + 1;
            end
        end
    end
endmodule

// File: port_egress_mask_vlan_bench.sv
/*
 * Self-checking bench for the egress permission block: APB master tasks,
 * one task per scenario, frames sent through the station model.
 * Assumes the block answers APB with one wait state.
 */
module port_egress_mask_vlan_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, arstN = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, fwdReq, fwdToCpu, fwdValid, saveStrobe;
    logic [3:0] fwdIngress;
    logic [47:0] fwdDstMac, fwdSrcMac;
    logic [12:0] fwdEgress, rxMask;
    logic [11:0] fwdVid, rxVid;
    logic [11:0][12:0] saveImage;
    logic go = 1'b0, goCpu = 1'b0;
    logic [3:0] goIngress = 4'h0;
    logic [47:0] goDst = 48'h0, goSrc = 48'h0;
    int rxCnt, n_mismatch = 0, num_checks = 0, nSave = 0;
    logic [31:0] rd;
    logic err;

    pemv_egress_filter dut (.clk(clk), .arst_n(arstN), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fwdReq(fwdReq), .fwdIngress(fwdIngress), .fwdDstMac(fwdDstMac), .fwdSrcMac(fwdSrcMac),
        .fwdToCpu(fwdToCpu), .fwdValid(fwdValid), .fwdEgress(fwdEgress), .fwdVid(fwdVid),
        .saveStrobe(saveStrobe), .saveImage(saveImage));
    pemv_station station (.clk(clk), .arst_n(arstN), .go(go), .goIngress(goIngress), .goDst(goDst),
        .goSrc(goSrc), .goCpu(goCpu), .fwdReq(fwdReq), .fwdIngress(fwdIngress), .fwdDstMac(fwdDstMac),
        .fwdSrcMac(fwdSrcMac), .fwdToCpu(fwdToCpu), .fwdValid(fwdValid), .fwdEgress(fwdEgress),
        .fwdVid(fwdVid), .rxMask(rxMask), .rxVid(rxVid), .rxCnt(rxCnt));

    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (saveStrobe === 1'b1) nSave <= nSave + 1;

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("apb ready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic frame(input logic [3:0] ing, input logic [47:0] dst, input logic [47:0] src,
                         input logic cpu, input logic [12:0] exp);
        int c0, n;
        c0 = rxCnt;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        goIngress <= ing;
        goDst <= dst;
        goSrc <= src;
        goCpu <= cpu;
        @(posedge clk);
        go <= 1'b0;
        while (rxCnt == c0 && n < 10) begin
            @(posedge clk);
            n++;
        end
        chk("frame answered", c0 + 1, rxCnt);
        chk("egress mask", {19'h0, exp}, {19'h0, rxMask});
        chk("vlan id", 32'h1, {20'h0, rxVid});
    endtask

    task automatic t_reset;
        rdchk("ctrl", pemv_pkg::OFS_CTRL, 32'h1);
        rdchk("vid reg", pemv_pkg::OFS_VID, 32'h1);
        rdchk("col 0", pemv_pkg::OFS_COL0, 32'h1fff);
        rdchk("col 11", pemv_pkg::OFS_COLN, 32'h1fff);
        frame(4'h0, 48'h0a0000000001, 48'h0a0000000010, 1'b0, 13'h1ffe);
        $display("test reset done");
    endtask
    task automatic t_isolate;
        apb(1'b1, pemv_pkg::OFS_CTRL, 32'h5);
        rdchk("col 3 iso", 8'h4c, 32'h1000);
        frame(4'h2, 48'h0a00000000ee, 48'h0a0000000020, 1'b0, 13'h1000);
        frame(4'h2, 48'h0a00000000ee, 48'h0a0000000020, 1'b1, 13'h1000);
        $display("test isolate done");
    endtask
    task automatic t_columns;
        apb(1'b1, 8'h40, 32'h0002);
        apb(1'b1, 8'h44, 32'h1000);
        apb(1'b1, 8'h54, 32'h0000);
        rdchk("col 0", 8'h40, 32'h0002);
        rdchk("col 2", 8'h48, 32'h1000);
        frame(4'h1, 48'h0a00000000ee, 48'h0a00000000a1, 1'b0, 13'h1000);
        frame(4'h0, 48'h0a00000000a1, 48'h0a00000000b0, 1'b0, 13'h0002);
        frame(4'h1, 48'h0a00000000b0, 48'h0a00000000a1, 1'b0, 13'h0000);
        frame(4'h5, 48'h0a00000000ee, 48'h0a0000000050, 1'b1, 13'h0000);
        $display("test columns done");
    endtask
    task automatic t_all_and_save;
        apb(1'b1, pemv_pkg::OFS_CTRL, 32'h3);
        rdchk("col 4 all", 8'h50, 32'h1fff);
        frame(4'h1, 48'h0a00000000ee, 48'h0a00000000a1, 1'b1, 13'h1000);
        frame(4'h1, 48'h0a00000000ee, 48'h0a00000000a1, 1'b0, 13'h1ffd);
        apb(1'b1, 8'h40, 32'h0004);
        apb(1'b1, pemv_pkg::OFS_CTRL, 32'h9);
        repeat (3) @(posedge clk);
        chk("save pulses", 32'h1, nSave);
        chk("save image 0", 32'h4, {19'h0, saveImage[0]});
        $display("test all and save done");
    endtask
    task automatic t_refuse;
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, pemv_pkg::OFS_VID, 32'h5);
        chk("vid write err", 32'h1, {31'h0, err});
        rdchk("vid kept", pemv_pkg::OFS_VID, 32'h1);
        frame(4'hc, 48'h0a00000000ee, 48'h0a00000000c0, 1'b0, 13'h0000);
        rdchk("learned count", pemv_pkg::OFS_COUNT, 32'h5);
        apb(1'b1, pemv_pkg::OFS_CTRL, 32'h0);
        rdchk("ctrl off", pemv_pkg::OFS_CTRL, 32'h0);
        frame(4'h0, 48'h0a00000000ee, 48'h0a0000000010, 1'b0, 13'h1ffe);
        $display("test refuse done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk);
        arstN <= 1'b1;
        t_reset;
        t_isolate;
        t_columns;
        t_all_and_save;
        t_refuse;
        report_and_stop;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule
